// [bench/cal_ctrl_tb.sv]
`timescale 1ns/10ps
module cal_ctrl_tb;
    import cal_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
    logic [9:0]  i_wb_adr = '0;
    logic [3:0]  i_wb_sel = '0;
    logic [31:0] i_wb_dat = '0, o_wb_dat, r;
    logic        o_wb_ack, o_cca_busy, o_cca_valid, o_lbt_clear;
    logic        i_meas_done = 0, i_carrier_sense = 0, i_aret_start = 0;
    logic        i_aret_done = 0, i_force_cancel = 0, i_shr_detect = 0;
    logic        i_sym_valid = 0, i_frame_end = 0;
    logic [4:0]  i_energy_steps = '0;
    logic [7:0]  i_sym_corr = '0, o_lqi;
    logic        o_csma_active, o_lbt_active, o_flt, o_upl, o_ackt, o_prom;
    logic        o_lqi_valid, o_irq;
    int          num_errors = 0, n_tests = 0, n_cca = 0, n_clr = 0, n0;

    always #50 i_ref_clk = ~i_ref_clk;

    cal_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clk_en(1'b1),
        .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
        .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_meas_done(i_meas_done),
        .i_energy_steps(i_energy_steps), .i_carrier_sense(i_carrier_sense),
        .i_aret_start(i_aret_start), .i_aret_done(i_aret_done),
        .i_force_cancel(i_force_cancel), .i_shr_detect(i_shr_detect),
        .i_sym_valid(i_sym_valid), .i_sym_corr(i_sym_corr),
        .i_frame_end(i_frame_end), .o_cca_busy(o_cca_busy),
        .o_cca_valid(o_cca_valid), .o_lbt_clear(o_lbt_clear),
        .o_csma_active(o_csma_active), .o_lbt_active(o_lbt_active),
        .o_filter_reserved_frames(o_flt), .o_upload_reserved_frames(o_upl),
        .o_short_ack_time(o_ackt), .o_promiscuous_enable(o_prom),
        .o_lqi(o_lqi), .o_lqi_valid(o_lqi_valid), .o_irq(o_irq));

    // pulses are counted here so their exact cycle never races the checks
    always @(posedge i_ref_clk) begin
        if (o_cca_valid === 1'b1) n_cca <= n_cca + 1;
        if (o_lbt_clear === 1'b1) n_clr <= n_clr + 1;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // classic single cycle; waits on ack, never on a fixed latency
    task automatic wb(input logic we, input logic [7:0] idx,
                      input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= we;
        i_wb_adr <= {idx, 2'b00};
        i_wb_sel <= 4'hF;
        i_wb_dat <= {24'h00_0000, wd};
        do begin
            @(posedge i_ref_clk);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 20);
        chk({31'h0, o_wb_ack}, 32'h1);
        r = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        i_wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(r, exp);
    endtask

    // one-cycle strobe on a side input, then let the answer settle
    task automatic pulse(input int w);
        @(posedge i_ref_clk);
        case (w)
            0: i_meas_done <= 1'b1;
            1: i_aret_start <= 1'b1;
            2: i_aret_done <= 1'b1;
            3: i_force_cancel <= 1'b1;
            4: i_shr_detect <= 1'b1;
            5: i_frame_end <= 1'b1;
            default: i_sym_valid <= 1'b1;
        endcase
        @(posedge i_ref_clk);
        {i_meas_done, i_aret_start, i_aret_done, i_force_cancel} <= '0;
        {i_shr_detect, i_frame_end, i_sym_valid} <= '0;
        repeat (3) @(posedge i_ref_clk);
    endtask

    task automatic meas(input logic [4:0] st, input logic cs);
        i_energy_steps <= st;
        i_carrier_sense <= cs;
        pulse(0);
    endtask

    task automatic t_regs();
        rd(CAL_IDX_MODE, 32'h0000_0020);
        rd(CAL_IDX_THRES, 32'h0000_0077);
        rd(CAL_IDX_XCTRL, 32'h0000_0000);
        wr(CAL_IDX_XCTRL, 8'hFF);
        rd(CAL_IDX_XCTRL, 32'h0000_00F6);
        chk({28'h0, o_flt, o_upl, o_ackt, o_prom}, 32'h0000_000F);
        wr(CAL_IDX_XCTRL, 8'h00);
        chk({28'h0, o_flt, o_upl, o_ackt, o_prom}, 32'h0000_0000);
        wr(8'h30, 8'hAA);
        rd(8'h30, 32'h0000_0000);
    endtask

    // every mode against both inputs, energy on the threshold boundary
    task automatic t_cca();
        logic e, c, x;
        for (int m = 0; m < 4; m++) begin
            wr(CAL_IDX_MODE, {1'b0, m[1:0], 5'h00});
            for (int v = 0; v < 4; v++) begin
                e = v[1];
                c = v[0];
                x = (m == 0) ? (e | c) : (m == 1) ? e : (m == 2) ? c : e & c;
                n0 = n_cca;
                meas(e ? 5'd8 : 5'd7, c);
                chk({31'h0, o_cca_busy}, {31'h0, x});
                chk(n_cca - n0, 1);
            end
        end
        wr(CAL_IDX_THRES, 8'hF7);
        wr(CAL_IDX_MODE, 8'h40);
        meas(5'd0, 1'b1);
        chk({31'h0, o_cca_busy}, 32'h0);
        wr(CAL_IDX_THRES, 8'h77);
        wr(CAL_IDX_MODE, 8'h20);
    endtask

    task automatic t_irq();
        wr(CAL_IDX_ICLR, 8'h07);
        rd(CAL_IDX_STAT, 32'h0000_0000);
        wr(CAL_IDX_IEN, 8'h01);
        meas(5'd8, 1'b0);
        chk({31'h0, o_irq}, 32'h1);
        rd(CAL_IDX_STAT, 32'h0000_0001);
        wr(CAL_IDX_ICLR, 8'h01);
        repeat (2) @(posedge i_ref_clk);
        chk({31'h0, o_irq}, 32'h0);
        wr(CAL_IDX_IEN, 8'h00);
        meas(5'd8, 1'b0);
        chk({31'h0, o_irq}, 32'h0);
        rd(CAL_IDX_STAT, 32'h0000_0001);
        wr(CAL_IDX_ICLR, 8'h07);
    endtask

    task automatic t_access();
        wr(CAL_IDX_XCTRL, 8'h40);
        n0 = n_cca;
        pulse(1);
        chk({o_lbt_active, o_csma_active}, 2'b10);
        meas(5'd8, 1'b0);
        chk({31'h0, o_lbt_active}, 32'h1);
        chk(n_clr, 0);
        meas(5'd7, 1'b0);
        chk(n_clr, 1);
        chk({31'h0, o_lbt_active}, 32'h0);
        chk(n_cca - n0, 0);
        rd(CAL_IDX_STAT, 32'h0000_0004);
        wr(CAL_IDX_MODE, 8'h40);
        pulse(1);
        meas(5'd15, 1'b0);
        chk(n_clr, 2);
        pulse(1);
        pulse(3);
        chk({31'h0, o_lbt_active}, 32'h0);
        chk(n_clr, 2);
        wr(CAL_IDX_MODE, 8'h20);
        wr(CAL_IDX_XCTRL, 8'h00);
        pulse(1);
        chk({o_lbt_active, o_csma_active}, 2'b01);
        pulse(2);
        chk({31'h0, o_csma_active}, 32'h0);
        wr(CAL_IDX_ICLR, 8'h07);
    endtask

    // extremes of the range; a steady correlation gives its own mean
    task automatic t_lqi();
        logic [7:0] v;
        pulse(5);
        chk({31'h0, o_lqi_valid}, 32'h0);
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'h00 : 8'hFF;
            pulse(4);
            chk({31'h0, o_lqi_valid}, 32'h0);
            i_sym_corr <= v;
            repeat (4) pulse(6);
            pulse(5);
            chk({31'h0, o_lqi_valid}, 32'h1);
            chk({24'h0, o_lqi}, {24'h0, v});
            rd(CAL_IDX_LQI, {24'h0, v});
            rd(CAL_IDX_STAT, 32'h0000_0002);
            rd(CAL_IDX_RES, 32'h0000_0081);
            wr(CAL_IDX_ICLR, 8'h07);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #(100 * 20000);
        num_errors++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        t_regs();
        t_cca();
        t_irq();
        t_access();
        t_lqi();
        end_of_test();
    end
endmodule

// [logic/cal_ctrl.sv]
// Functional notes
// - mode 0 or, 1 energy, 2 carrier, 3 and
// - lbt select routes mode to lbt measurement
// - energy threshold resets 7, busy above it
// - lbt uses the energy threshold too; the code ignores it for lbt in mode 2 (carrier)
// - extended control fields, reset zero
// - retry transmit uses csma or lbt
// - link quality starts at header detect
// - link quality from symbol correlation mean
// - link quality is 0 to 255
// - link quality readable after frame end irq
// - lbt ignores retries, ends clear or forced
// - carrier threshold resets 7, 15 means clear
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
module cal_ctrl
    import cal_pkg::*;
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_clk_en,
    input  wire logic       i_wb_cyc,
    input  wire logic       i_wb_stb,
    input  wire logic       i_wb_we,
    input  wire logic [9:0] i_wb_adr,
    input  wire logic [3:0] i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]     o_wb_dat,
    output logic            o_wb_ack,
    input  wire logic       i_meas_done,
    input  wire logic [4:0] i_energy_steps,
    input  wire logic       i_carrier_sense,
    input  wire logic       i_aret_start,
    input  wire logic       i_aret_done,
    input  wire logic       i_force_cancel,
    input  wire logic       i_shr_detect,
    input  wire logic       i_sym_valid,
    input  wire logic [7:0] i_sym_corr,
    input  wire logic       i_frame_end,
    output logic            o_cca_busy,
    output logic            o_cca_valid,
    output logic            o_lbt_clear,
    output logic            o_csma_active,
    output logic            o_lbt_active,
    output logic            o_filter_reserved_frames,
    output logic            o_upload_reserved_frames,
    output logic            o_short_ack_time,
    output logic            o_promiscuous_enable,
    output logic [7:0]      o_lqi,
    output logic            o_lqi_valid,
    output logic            o_irq
);
    typedef struct packed {
        logic                 ack;
        logic [7:0]           rdat;
        logic [1:0]           mode;
        logic [7:0]           thres;
        logic [7:0]           xctrl;
        logic [CAL_IRQ_W-1:0] stat;
        logic [CAL_IRQ_W-1:0] ien;
        cal_acc_t             acc;
        logic                 busy;
        logic                 valid;
        logic                 lbt_clear;
        logic [7:0]           lqi;
        logic                 lqi_valid;
        logic                 irq;
    } cal_st_t;

    cal_st_t st_r;
    cal_st_t st_nxt;
    cal_lqi_if lq ();

    // busy decision shared by logic and checks
    function automatic logic cal_busy(input logic [1:0] mode,
                                      input logic [7:0] thres,
                                      input logic [4:0] steps,
                                      input logic       cs);
        logic ed;
        logic cs_eff;
        ed = steps > {1'b0, thres[CAL_ED_MSB:CAL_ED_LSB]};
        // a carrier threshold of 15 hides every carrier
        cs_eff = cs && (thres[CAL_CS_MSB:CAL_CS_LSB] != CAL_CS_CLEAR);
        case (mode)
            CAL_M_OR:  cal_busy = cs_eff | ed;
            CAL_M_ED:  cal_busy = ed;
            CAL_M_CS:  cal_busy = cs_eff;
            CAL_M_AND: cal_busy = cs_eff & ed;
            default:   cal_busy = ed;
        endcase
    endfunction

    logic       wb_req;
    logic       wb_wr;
    logic [7:0] wb_idx;
    logic       meas_busy;
    logic       lbt_sel;
    logic [CAL_IRQ_W-1:0] ev;

    assign wb_req = i_wb_cyc && i_wb_stb && !st_r.ack;
    assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];
    assign wb_idx = i_wb_adr[9:2];
    assign meas_busy = cal_busy(st_r.mode, st_r.thres, i_energy_steps,
                                i_carrier_sense);
    assign lbt_sel = st_r.xctrl[CAL_X_LBT];

    // estimator hookup
    assign lq.start = i_shr_detect;
    assign lq.sym_valid = i_sym_valid;
    assign lq.corr = i_sym_corr;
    assign lq.frame_end = i_frame_end;

    cal_lqi_est u_lqi (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_clk_en  (i_clk_en),
        .lq        (lq.est)
    );

    // register file, access state machine, events
    always_comb begin
        st_nxt = st_r;
        ev = '0;
        st_nxt.ack = wb_req;
        st_nxt.valid = 1'b0;
        st_nxt.lbt_clear = 1'b0;

        // reads: unmapped indices answer zero
        st_nxt.rdat = '0;
        if (wb_req && !i_wb_we) begin
            case (wb_idx)
                CAL_IDX_MODE:
                    st_nxt.rdat[CAL_MODE_MSB:CAL_MODE_LSB] = st_r.mode;
                CAL_IDX_THRES: st_nxt.rdat = st_r.thres;
                CAL_IDX_XCTRL: st_nxt.rdat = st_r.xctrl;
                CAL_IDX_STAT:  st_nxt.rdat = {5'h00, st_r.stat};
                CAL_IDX_IEN:   st_nxt.rdat = {5'h00, st_r.ien};
                CAL_IDX_LQI:   st_nxt.rdat = st_r.lqi;
                CAL_IDX_RES:   st_nxt.rdat = {st_r.lqi_valid, 5'h00,
                                              st_r.valid, st_r.busy};
                default:       st_nxt.rdat = '0;
            endcase
        end

        // writes on byte lane 0 only; registers are eight bits
        if (wb_wr) begin
            case (wb_idx)
                CAL_IDX_MODE:
                    st_nxt.mode = i_wb_dat[CAL_MODE_MSB:CAL_MODE_LSB];
                CAL_IDX_THRES:
                    st_nxt.thres = i_wb_dat[7:0];
                CAL_IDX_XCTRL:
                    st_nxt.xctrl = i_wb_dat[7:0] & CAL_XCTRL_WM;
                CAL_IDX_IEN:
                    st_nxt.ien = i_wb_dat[CAL_IRQ_W-1:0];
                CAL_IDX_ICLR:
                    st_nxt.stat = st_r.stat & ~i_wb_dat[CAL_IRQ_W-1:0];
                default: ;
            endcase
        end

        // measurement result goes to cca, or to lbt listening; with lbt selected but not listening it is dropped
        if (i_meas_done) begin
            if (lbt_sel && st_r.acc == CAL_AC_LISTEN) begin
                if (!meas_busy) begin
                    st_nxt.lbt_clear = 1'b1;
                    ev[CAL_IRQ_LBT] = 1'b1;
                end
            end else if (!lbt_sel) begin
                st_nxt.busy = meas_busy;
                st_nxt.valid = 1'b1;
                ev[CAL_IRQ_CCA] = 1'b1;
            end
        end

        // channel access during retrying transmit
        case (st_r.acc)
            CAL_AC_IDLE: begin
                if (i_aret_start) begin
                    st_nxt.acc = lbt_sel ? CAL_AC_LISTEN : CAL_AC_CSMA;
                end
            end
            CAL_AC_CSMA: begin
                if (i_aret_done || i_force_cancel) begin
                    st_nxt.acc = CAL_AC_IDLE;
                end
            end
            CAL_AC_LISTEN: begin
                // retry limit and backoff never end listening
                if (i_force_cancel || st_nxt.lbt_clear) begin
                    st_nxt.acc = CAL_AC_IDLE;
                end
            end
            default: st_nxt.acc = CAL_AC_IDLE;
        endcase

        // link quality published with the frame end event
        if (lq.done) begin
            st_nxt.lqi = lq.lqi;
            st_nxt.lqi_valid = 1'b1;
            ev[CAL_IRQ_FEND] = 1'b1;
        end else if (i_shr_detect) begin
            st_nxt.lqi_valid = 1'b0;
        end

        // sticky status: a new event beats a same-cycle clear
        st_nxt.stat = st_nxt.stat | ev;
        st_nxt.irq = |(st_nxt.stat & st_r.ien);
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
            st_r.mode <= CAL_MODE_RST;
            st_r.thres <= CAL_THRES_RST;
            st_r.xctrl <= CAL_XCTRL_RST;
            st_r.acc <= CAL_AC_IDLE;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from state flops
    assign o_wb_ack = st_r.ack;
    assign o_wb_dat = {24'h00_0000, st_r.rdat};
    assign o_cca_busy = st_r.busy;
    assign o_cca_valid = st_r.valid;
    assign o_lbt_clear = st_r.lbt_clear;
    assign o_csma_active = (st_r.acc == CAL_AC_CSMA);
    assign o_lbt_active = (st_r.acc == CAL_AC_LISTEN);
    assign o_filter_reserved_frames = st_r.xctrl[CAL_X_FLTR];
    assign o_upload_reserved_frames = st_r.xctrl[CAL_X_UPLD];
    assign o_short_ack_time = st_r.xctrl[CAL_X_ACKT];
    assign o_promiscuous_enable = st_r.xctrl[CAL_X_PROM];
    assign o_lqi = st_r.lqi;
    assign o_lqi_valid = st_r.lqi_valid;
    assign o_irq = st_r.irq;

    // checks
    AST_CCA_DECIDE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && i_meas_done && !lbt_sel) |=>
        (o_cca_valid && o_cca_busy == $past(meas_busy)))
        else $error("cca result not taken from decision");
    AST_LBT_ROUTE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && i_meas_done && lbt_sel) |=> !o_cca_valid)
        else $error("cca reported while lbt selected");
    AST_ED_ONLY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (st_r.mode == CAL_M_ED) |->
        (meas_busy == (i_energy_steps > {1'b0, st_r.thres[3:0]})))
        else $error("energy compare wrong");
    AST_LBT_THR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && i_meas_done && lbt_sel && o_lbt_active
         && st_r.mode == CAL_M_ED
         && i_energy_steps <= {1'b0, st_r.thres[3:0]}) |=> o_lbt_clear)
        else $error("lbt clear missed under threshold");
    AST_XRES: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (st_r.xctrl[3] == 1'b0 && st_r.xctrl[0] == 1'b0))
        else $error("reserved control bit set");
    AST_ACC_SEL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && st_r.acc == CAL_AC_IDLE && i_aret_start) |=>
        (o_lbt_active == $past(lbt_sel) && o_csma_active != $past(lbt_sel)))
        else $error("wrong access method chosen");
    AST_LISTEN_HOLD: assert property (@(posedge i_ref_clk)
        disable iff (i_rst)
        (i_clk_en && o_lbt_active && !i_force_cancel && !i_meas_done)
        |=> o_lbt_active)
        else $error("listening ended without clear or cancel");
    AST_CS_CLEAR: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (st_r.mode == CAL_M_CS && st_r.thres[7:4] == CAL_CS_CLEAR)
        |-> !meas_busy)
        else $error("carrier threshold 15 not clear");
    AST_FEND_IRQ: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && lq.done) |=>
        (st_r.stat[CAL_IRQ_FEND] && o_lqi_valid && o_lqi == $past(lq.lqi)))
        else $error("lqi not published with frame end");
    AST_IRQ_LVL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && !wb_wr && !i_meas_done && !lq.done) |=>
        (o_irq == |($past(st_r.stat) & $past(st_r.ien))))
        else $error("irq level mismatch");

    COV_CCA_BUSY: cover property (@(posedge i_ref_clk)
        o_cca_valid && o_cca_busy);
    COV_LBT_CLEAR: cover property (@(posedge i_ref_clk) o_lbt_clear);
    COV_LQI: cover property (@(posedge i_ref_clk) o_lqi_valid && o_irq);
endmodule

// [logic/cal_lqi_est.sv]
`timescale 1ns/10ps
module cal_lqi_est
    import cal_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_clk_en,
    cal_lqi_if.est    lq
);
    typedef struct packed {
        logic                 run;
        logic                 first;
        logic [CAL_ACC_W-1:0] acc;
        logic [7:0]           lqi;
        logic                 done;
    } cal_lqi_st_t;

    cal_lqi_st_t st_r;
    cal_lqi_st_t st_nxt;

    // acc holds eight times a running mean of symbol correlation
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (lq.start) begin
            st_nxt.run = 1'b1;
            st_nxt.first = 1'b1;
            st_nxt.acc = '0;
        end else if (st_r.run && lq.sym_valid) begin
            st_nxt.first = 1'b0;
            if (st_r.first) begin
                st_nxt.acc = {lq.corr, 3'b000};
            end else begin
                st_nxt.acc = st_r.acc - (st_r.acc >> CAL_LQI_SH)
                             + {3'b000, lq.corr};
            end
        end
        if (lq.frame_end && st_r.run) begin
            st_nxt.run = 1'b0;
            st_nxt.done = 1'b1;
            // mean of 8-bit values never passes the 8-bit maximum
            st_nxt.lqi = st_r.acc[CAL_ACC_W-1:CAL_LQI_SH];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= '0;
        end else if (i_clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign lq.lqi = st_r.lqi;
    assign lq.done = st_r.done;

    AST_LQI_DONE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && lq.frame_end && st_r.run) |=> lq.done)
        else $error("lqi done missing after frame end");
    AST_LQI_START: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_clk_en && lq.start) |=> (st_r.run && st_r.first))
        else $error("lqi did not start on header");
endmodule

// [logic/cal_lqi_if.sv]
`timescale 1ns/10ps
interface cal_lqi_if;
    logic       start;
    logic       sym_valid;
    logic [7:0] corr;
    logic       frame_end;
    logic [7:0] lqi;
    logic       done;
    modport ctrl (output start, sym_valid, corr, frame_end,
                  input lqi, done);
    modport est (input start, sym_valid, corr, frame_end,
                 output lqi, done);
endinterface

// [logic/cal_pkg.sv]
package cal_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] CAL_IDX_MODE  = 8'h08;
    localparam logic [7:0] CAL_IDX_THRES = 8'h09;
    localparam logic [7:0] CAL_IDX_XCTRL = 8'h17;
    localparam logic [7:0] CAL_IDX_STAT  = 8'h20;
    localparam logic [7:0] CAL_IDX_IEN   = 8'h21;
    localparam logic [7:0] CAL_IDX_ICLR  = 8'h22;
    localparam logic [7:0] CAL_IDX_LQI   = 8'h23;
    localparam logic [7:0] CAL_IDX_RES   = 8'h24;

    // field positions
    localparam int CAL_MODE_LSB = 5;
    localparam int CAL_MODE_MSB = 6;
    localparam int CAL_ED_LSB   = 0;
    localparam int CAL_ED_MSB   = 3;
    localparam int CAL_CS_LSB   = 4;
    localparam int CAL_CS_MSB   = 7;
    localparam int CAL_X_LBT    = 6;
    localparam int CAL_X_FLTR   = 5;
    localparam int CAL_X_UPLD   = 4;
    localparam int CAL_X_ACKT   = 2;
    localparam int CAL_X_PROM   = 1;

    // reset values and masks
    localparam logic [1:0] CAL_MODE_RST  = 2'h1;
    localparam logic [7:0] CAL_THRES_RST = 8'h77;
    localparam logic [7:0] CAL_XCTRL_RST = 8'h00;
    localparam logic [7:0] CAL_XCTRL_WM  = 8'hF6;
    localparam logic [3:0] CAL_CS_CLEAR  = 4'hF;

    // assessment modes
    localparam logic [1:0] CAL_M_OR  = 2'h0;
    localparam logic [1:0] CAL_M_ED  = 2'h1;
    localparam logic [1:0] CAL_M_CS  = 2'h2;
    localparam logic [1:0] CAL_M_AND = 2'h3;

    // interrupt bits
    localparam int CAL_IRQ_W    = 3;
    localparam int CAL_IRQ_CCA  = 0;
    localparam int CAL_IRQ_FEND = 1;
    localparam int CAL_IRQ_LBT  = 2;

    // link quality running mean: weight 1/8
    localparam int CAL_LQI_SH = 3;
    localparam int CAL_ACC_W  = 11;
    localparam logic [7:0] CAL_LQI_MAX = 8'hFF;

    typedef enum logic [1:0] {
        CAL_AC_IDLE,
        CAL_AC_CSMA,
        CAL_AC_LISTEN
    } cal_acc_t;
endpackage
